// >>> rtcfg_bus_model.sv
// bus-side partner: rt-rt window marks and mode-command pulses
// assumes callers start just after a core_clk rise
`timescale 1ns/1ps
module rtcfg_bus_model (
    input wire logic core_clk,
    output logic rtRtWindowStart,
    output logic firstDataSync,
    output logic modeResetValid
);
    initial begin
        rtRtWindowStart = 1'b0;
        firstDataSync = 1'b0;
        modeResetValid = 1'b0;
    end

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : step

    // receive mid-parity, then first data mid-sync after gap (0 = none)
    task automatic rt_rt(input int gap);
        rtRtWindowStart = 1'b1;
        step(1);
        rtRtWindowStart = 1'b0;
        if (gap > 0) begin
            step(gap - 1);
            firstDataSync = 1'b1;
            step(1);
            firstDataSync = 1'b0;
        end
    endtask : rt_rt

    // valid reset-terminal mode command
    task automatic mode_reset();
        modeResetValid = 1'b1;
        step(1);
        modeResetValid = 1'b0;
    endtask : mode_reset
endmodule : rtcfg_bus_model

// >>> rtcfg_pkg.sv
// constants, field layout and carrier types for the terminal configuration block
// assumes a 100 MHz core clock and host access over a 4-wire serial port
package rtcfg_pkg;
    localparam logic [6:0] ADDR_MASTER_CFG = 7'h00;
    localparam logic [6:0] ADDR_MASTER_STAT = 7'h01;
    localparam logic [6:0] ADDR_RT_CFG = 7'h17;
    localparam logic [6:0] ADDR_RT_TABLES = 7'h18;
    localparam int MCFG_TX_ONLY_BIT = 3;
    localparam int MCFG_MODE_RST_EN_BIT = 2;
    localparam int MSTAT_RT_RESET_BIT = 0;
    localparam int MSTAT_BLOCK_A_BIT = 9;
    localparam int MSTAT_BLOCK_B_BIT = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam int SPI_HDR_BITS = 8;
    localparam int SPI_DATA_BITS = 16;
    localparam int CLK_PERIOD_NS = 10;
    localparam int TIMEOUT0_NS = 57000;
    localparam int TIMEOUT1_NS = 62000;
    localparam int TIMEOUT2_NS = 122000;
    localparam int TIMEOUT3_NS = 180000;
    localparam int TIMEOUT0_CYC = TIMEOUT0_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT1_CYC = TIMEOUT1_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT2_CYC = TIMEOUT2_NS / CLK_PERIOD_NS;
    localparam int TIMEOUT3_CYC = TIMEOUT3_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [1:0] rt_to_rt_timeout_sel;
        logic terminal_bus_a_block;
        logic terminal_bus_b_block;
        logic [11:0] otherBits;
    } rtcfg_cfg_t;

    typedef struct packed {
        logic wrStrobe;
        logic [6:0] addr;
        logic [15:0] wdata;
    } rtcfg_wr_t;
endpackage : rtcfg_pkg

// >>> rtcfg_spi_slave.sv
// serial host port: 1 write flag, 7 address bits, 16 data bits, msb first
// assumes mode 0 framing with pins asynchronous to core_clk
`timescale 1ns/1ps
module rtcfg_spi_slave
    import rtcfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire logic [15:0] rdData,
    output logic [6:0] rdAddr,
    output rtcfg_wr_t wrReq,
    output logic spiMiso,
    output logic spiMisoOe
);
    logic [2:0] meta_q, meta_d;
    logic [2:0] sync_q, sync_d;
    logic sclkLast_q, sclkLast_d;
    logic [4:0] bitCnt_q, bitCnt_d;
    logic [23:0] shIn_q, shIn_d;
    logic [15:0] shOut_q, shOut_d;
    rtcfg_wr_t wr_q, wr_d;
    logic miso_q, miso_d;
    logic oe_q, oe_d;
    logic rise;
    logic fall;

    always_comb begin
        meta_d = {spiSclk, spiCsN, spiMosi};
        sync_d = meta_q;
        sclkLast_d = sync_q[2];
        rise = sync_q[2] & ~sclkLast_q;
        fall = ~sync_q[2] & sclkLast_q;
        bitCnt_d = bitCnt_q;
        shIn_d = shIn_q;
        shOut_d = shOut_q;
        wr_d = wr_q;
        wr_d.wrStrobe = 1'b0;
        miso_d = miso_q;
        oe_d = ~sync_q[1];
        if (sync_q[1]) begin
            bitCnt_d = 5'h00;
            miso_d = 1'b0;
        end else if (rise) begin
            shIn_d = {shIn_q[22:0], sync_q[0]};
            bitCnt_d = bitCnt_q + 5'h01;
            if (bitCnt_q == 5'(SPI_HDR_BITS - 1)) begin
                shOut_d = rdData;
            end
            if (bitCnt_q == 5'(SPI_HDR_BITS + SPI_DATA_BITS - 1) && shIn_q[22]) begin
                wr_d.wrStrobe = 1'b1;
                wr_d.addr = shIn_q[21:15];
                wr_d.wdata = {shIn_q[14:0], sync_q[0]};
            end
        end else if (fall && bitCnt_q >= 5'(SPI_HDR_BITS)) begin
            miso_d = shOut_q[15];
            shOut_d = {shOut_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
            sclkLast_q <= 1'b0;
            bitCnt_q <= 5'h00;
            shIn_q <= 24'h000000;
            shOut_q <= 16'h0000;
            wr_q <= '0;
            miso_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            sclkLast_q <= sclkLast_d;
            bitCnt_q <= bitCnt_d;
            shIn_q <= shIn_d;
            shOut_q <= shOut_d;
            wr_q <= wr_d;
            miso_q <= miso_d;
            oe_q <= oe_d;
        end
    end

    // address completes on the 8th rise, so take the bit being sampled now
    assign rdAddr = {shIn_q[5:0], sync_q[0]};
    assign wrReq = wr_q;
    assign spiMiso = miso_q;
    assign spiMisoOe = oe_q;
endmodule : rtcfg_spi_slave

// >>> rtcfg_top.sv
// terminal configuration: registers, soft reset, bus inhibits, rt-rt timer
// assumes protocol logic on core_clk gives pulses; pins are asynchronous
`timescale 1ns/1ps
module rtcfg_top
    import rtcfg_pkg::*;
#(
    parameter int unsigned TIMEOUT0_CYCLES = TIMEOUT0_CYC,
    parameter int unsigned TIMEOUT1_CYCLES = TIMEOUT1_CYC,
    parameter int unsigned TIMEOUT2_CYCLES = TIMEOUT2_CYC,
    parameter int unsigned TIMEOUT3_CYCLES = TIMEOUT3_CYC
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    input wire logic [4:0] termAddrPin,
    input wire logic termAddrParityPin,
    input wire logic global_bus_a_tx_block_pin,
    input wire logic global_bus_b_tx_block_pin,
    input wire logic rtRtWindowStart,
    input wire logic firstDataSync,
    input wire logic modeResetValid,
    output logic rtSoftReset,
    output logic busATxBlock,
    output logic busARxBlock,
    output logic busBTxBlock,
    output logic busBRxBlock,
    output logic rtRtTimeout,
    output logic termAddrValid,
    output logic [4:0] termAddr,
    output logic [15:0] rtTablesBase
);
    function automatic logic [14:0] timeoutLimit(input logic [1:0] sel);
        case (sel)
            2'h0: timeoutLimit = 15'(TIMEOUT0_CYCLES);
            2'h1: timeoutLimit = 15'(TIMEOUT1_CYCLES);
            2'h2: timeoutLimit = 15'(TIMEOUT2_CYCLES);
            default: timeoutLimit = 15'(TIMEOUT3_CYCLES);
        endcase
    endfunction : timeoutLimit

    rtcfg_wr_t wrReq;
    logic [6:0] rdAddr;
    logic [15:0] rdData;
    rtcfg_cfg_t rtCfg_q, rtCfg_d;
    logic [15:0] mstrCfg_q, mstrCfg_d;
    logic [15:0] mstrStat_q, mstrStat_d;
    logic [15:0] tables_q, tables_d;
    logic softRst_q, softRst_d;
    logic [7:0] pinMeta_q, pinSync_q;
    logic txA_q, txA_d, rxA_q, rxA_d, txB_q, txB_d, rxB_q, rxB_d;
    logic addrValid_q, addrValid_d;
    logic [4:0] addr_q, addr_d;
    logic timerRun_q, timerRun_d;
    logic [14:0] timerCnt_q, timerCnt_d;
    logic timeout_q, timeout_d;
    logic wrHit;

    rtcfg_spi_slave u_spi (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .spiSclk(spiSclk),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .rdData(rdData),
        .rdAddr(rdAddr),
        .wrReq(wrReq),
        .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe)
    );

    // register file and soft reset
    always_comb begin
        rtCfg_d = rtCfg_q;
        mstrCfg_d = mstrCfg_q;
        mstrStat_d = mstrStat_q;
        tables_d = tables_q;
        wrHit = wrReq.wrStrobe;
        softRst_d = (wrHit && wrReq.addr == ADDR_MASTER_STAT
            && wrReq.wdata[MSTAT_RT_RESET_BIT])
            || (modeResetValid && mstrCfg_q[MCFG_MODE_RST_EN_BIT]);
        if (wrHit) begin
            case (wrReq.addr)
                ADDR_MASTER_CFG: mstrCfg_d = wrReq.wdata;
                ADDR_MASTER_STAT: begin
                    mstrStat_d = wrReq.wdata;
                    mstrStat_d[MSTAT_RT_RESET_BIT] = 1'b0;
                end
                ADDR_RT_CFG: rtCfg_d = wrReq.wdata;
                ADDR_RT_TABLES: tables_d = wrReq.wdata;
                default: ;
            endcase
        end
        if (softRst_q) begin
            rtCfg_d = REG_RESET;
            tables_d = REG_RESET;
        end
        case (rdAddr)
            ADDR_MASTER_CFG: rdData = mstrCfg_q;
            ADDR_MASTER_STAT: rdData = mstrStat_q;
            ADDR_RT_CFG: rdData = rtCfg_q;
            ADDR_RT_TABLES: rdData = tables_q;
            default: rdData = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rtCfg_q <= REG_RESET;
            mstrCfg_q <= REG_RESET;
            mstrStat_q <= REG_RESET;
            tables_q <= REG_RESET;
            softRst_q <= 1'b0;
        end else begin
            rtCfg_q <= rtCfg_d;
            mstrCfg_q <= mstrCfg_d;
            mstrStat_q <= mstrStat_d;
            tables_q <= tables_d;
            softRst_q <= softRst_d;
        end
    end

    // pin synchronisers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pinMeta_q <= 8'h00;
            pinSync_q <= 8'h00;
        end else begin
            pinMeta_q <= {global_bus_a_tx_block_pin, global_bus_b_tx_block_pin,
                termAddrParityPin, termAddrPin};
            pinSync_q <= pinMeta_q;
        end
    end

    // bus inhibits and address check
    always_comb begin
        txA_d = rtCfg_q.terminal_bus_a_block | pinSync_q[7] | mstrStat_q[MSTAT_BLOCK_A_BIT];
        rxA_d = rtCfg_q.terminal_bus_a_block & ~mstrCfg_q[MCFG_TX_ONLY_BIT];
        txB_d = rtCfg_q.terminal_bus_b_block | pinSync_q[6] | mstrStat_q[MSTAT_BLOCK_B_BIT];
        rxB_d = rtCfg_q.terminal_bus_b_block & ~mstrCfg_q[MCFG_TX_ONLY_BIT];
        addrValid_d = ^pinSync_q[5:0];
        addr_d = pinSync_q[4:0];
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txA_q <= 1'b0;
            rxA_q <= 1'b0;
            txB_q <= 1'b0;
            rxB_q <= 1'b0;
            addrValid_q <= 1'b0;
            addr_q <= 5'h00;
        end else begin
            txA_q <= txA_d;
            rxA_q <= rxA_d;
            txB_q <= txB_d;
            rxB_q <= rxB_d;
            addrValid_q <= addrValid_d;
            addr_q <= addr_d;
        end
    end

    // rt-rt no-response timer
    always_comb begin
        timerRun_d = timerRun_q;
        timerCnt_d = timerCnt_q;
        timeout_d = 1'b0;
        if (softRst_q || firstDataSync) begin
            timerRun_d = 1'b0;
        end else if (rtRtWindowStart) begin
            timerRun_d = 1'b1;
            timerCnt_d = 15'h0000;
        end else if (timerRun_q) begin
            timerCnt_d = timerCnt_q + 15'h0001;
            if (timerCnt_q == timeoutLimit(rtCfg_q.rt_to_rt_timeout_sel) - 15'h0001) begin
                timeout_d = 1'b1;
                timerRun_d = 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            timerRun_q <= 1'b0;
            timerCnt_q <= 15'h0000;
            timeout_q <= 1'b0;
        end else begin
            timerRun_q <= timerRun_d;
            timerCnt_q <= timerCnt_d;
            timeout_q <= timeout_d;
        end
    end

    assign rtSoftReset = softRst_q;
    assign busATxBlock = txA_q;
    assign busARxBlock = rxA_q;
    assign busBTxBlock = txB_q;
    assign busBRxBlock = rxB_q;
    assign rtRtTimeout = timeout_q;
    assign termAddrValid = addrValid_q;
    assign termAddr = addr_q;
    assign rtTablesBase = tables_q;

    property p_timeout_count;
        @(posedge core_clk) disable iff (sys_rst)
        rtRtTimeout |-> $past(timerCnt_q) ==
            timeoutLimit($past(rtCfg_q.rt_to_rt_timeout_sel)) - 15'h0001;
    endproperty
    a_timeout_count: assert property (p_timeout_count) else $error("timeout at wrong count");

    property p_sync_stops;
        @(posedge core_clk) disable iff (sys_rst)
        firstDataSync |=> !timerRun_q ##1 !rtRtTimeout;
    endproperty
    a_sync_stops: assert property (p_sync_stops) else $error("timer ran past data sync");

    property p_cfg_write;
        @(posedge core_clk) disable iff (sys_rst)
        (wrReq.wrStrobe && wrReq.addr == ADDR_RT_CFG && !softRst_q)
            |=> rtCfg_q == $past(wrReq.wdata);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    property p_block_a;
        @(posedge core_clk) disable iff (sys_rst)
        rtCfg_q.terminal_bus_a_block |=> busATxBlock && (busARxBlock != $past(mstrCfg_q[3]));
    endproperty
    a_block_a: assert property (p_block_a) else $error("bus A not blocked");

    property p_free_a;
        @(posedge core_clk) disable iff (sys_rst)
        !(rtCfg_q.terminal_bus_a_block || pinSync_q[7] || mstrStat_q[MSTAT_BLOCK_A_BIT])
            |=> !busATxBlock && !busARxBlock;
    endproperty
    a_free_a: assert property (p_free_a) else $error("bus A blocked without cause");

    property p_block_b;
        @(posedge core_clk) disable iff (sys_rst)
        ##1 busBTxBlock == $past(rtCfg_q.terminal_bus_b_block || pinSync_q[6]
            || mstrStat_q[MSTAT_BLOCK_B_BIT]);
    endproperty
    a_block_b: assert property (p_block_b) else $error("bus B block mismatch");

    property p_host_reset;
        @(posedge core_clk) disable iff (sys_rst)
        (wrReq.wrStrobe && wrReq.addr == ADDR_MASTER_STAT && wrReq.wdata[0])
            |=> rtSoftReset ##1 (rtCfg_q == REG_RESET);
    endproperty
    a_host_reset: assert property (p_host_reset) else $error("soft reset missed");

    property p_mode_reset;
        @(posedge core_clk) disable iff (sys_rst)
        (modeResetValid && mstrCfg_q[MCFG_MODE_RST_EN_BIT]) |=> rtSoftReset;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode reset ignored");

    property p_addr_parity;
        @(posedge core_clk) disable iff (sys_rst)
        ##1 termAddrValid == $past(^pinSync_q[5:0]);
    endproperty
    a_addr_parity: assert property (p_addr_parity) else $error("address parity wrong");
endmodule : rtcfg_top

// >>> tb.sv
// self-checking bench for the terminal configuration block
// assumes short timeout parameters and a slow serial host clock
`timescale 1ns/1ps
module tb;
    import rtcfg_pkg::*;
    localparam int LIM[4] = '{20, 30, 40, 50};
    logic core_clk, sys_rst, spiSclk, spiCsN, spiMosi, spiMiso, spiMisoOe;
    logic [4:0] termAddrPin, termAddr;
    logic termAddrParityPin, termAddrValid, rtSoftReset, rtRtTimeout;
    logic global_bus_a_tx_block_pin, global_bus_b_tx_block_pin;
    logic rtRtWindowStart, firstDataSync, modeResetValid;
    logic busATxBlock, busARxBlock, busBTxBlock, busBRxBlock;
    logic [15:0] rtTablesBase;
    int miscompares = 0;
    int nChecks = 0;
    int cycles = 0;
    int softCount = 0;

    rtcfg_top #(.TIMEOUT0_CYCLES(LIM[0]), .TIMEOUT1_CYCLES(LIM[1]),
        .TIMEOUT2_CYCLES(LIM[2]), .TIMEOUT3_CYCLES(LIM[3])) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .spiSclk(spiSclk), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
        .termAddrPin(termAddrPin), .termAddrParityPin(termAddrParityPin),
        .global_bus_a_tx_block_pin(global_bus_a_tx_block_pin),
        .global_bus_b_tx_block_pin(global_bus_b_tx_block_pin),
        .rtRtWindowStart(rtRtWindowStart), .firstDataSync(firstDataSync),
        .modeResetValid(modeResetValid), .rtSoftReset(rtSoftReset),
        .busATxBlock(busATxBlock), .busARxBlock(busARxBlock),
        .busBTxBlock(busBTxBlock), .busBRxBlock(busBRxBlock),
        .rtRtTimeout(rtRtTimeout), .termAddrValid(termAddrValid),
        .termAddr(termAddr), .rtTablesBase(rtTablesBase));

    rtcfg_bus_model busModel (.core_clk(core_clk), .rtRtWindowStart(rtRtWindowStart),
        .firstDataSync(firstDataSync), .modeResetValid(modeResetValid));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles++;
        if (rtSoftReset === 1'b1) softCount++;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : cyc

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic spi(input logic w, input logic [6:0] a, input logic [15:0] d,
        output logic [15:0] q);
        logic [23:0] f;
        f = {w, a, d};
        q = 16'h0000;
        spiCsN = 1'b0;
        cyc(5);
        for (int i = 23; i >= 0; i--) begin
            spiMosi = f[i];
            cyc(5);
            if (i < 16) q = {q[14:0], spiMiso};
            if (i == 0) chk("misoOe", 16'h0001, {15'h0000, spiMisoOe});
            spiSclk = 1'b1;
            cyc(5);
            spiSclk = 1'b0;
        end
        cyc(5);
        spiCsN = 1'b1;
        cyc(6);
    endtask : spi

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        logic [15:0] q;
        spi(1'b1, a, d, q);
    endtask : wr

    task automatic rd(input logic [6:0] a, input logic [15:0] exp, input string what);
        logic [15:0] q;
        spi(1'b0, a, 16'h0000, q);
        chk(what, exp, q);
    endtask : rd

    task automatic blk(input logic [3:0] exp, input string what);
        cyc(4);
        chk(what, {12'h000, exp}, {12'h000, busATxBlock, busARxBlock, busBTxBlock, busBRxBlock});
    endtask : blk

    task automatic t_regs();
        rd(ADDR_RT_CFG, 16'h0000, "cfgReset");
        blk(4'h0, "blockReset");
        wr(ADDR_RT_CFG, 16'hF000);
        rd(ADDR_RT_CFG, 16'hF000, "cfgBack");
        blk(4'hF, "blockBoth");
        wr(ADDR_MASTER_CFG, 16'h0008);
        blk(4'hA, "blockTxOnly");
        wr(ADDR_RT_CFG, 16'h1000);
        blk(4'h2, "blockBOnly");
        wr(ADDR_RT_CFG, 16'h4000);
        blk(4'h0, "blockNone");
        wr(ADDR_MASTER_CFG, 16'h0000);
        rd(7'h7F, 16'h0000, "unmapped");
    endtask : t_regs

    task automatic t_global();
        global_bus_a_tx_block_pin = 1'b1;
        blk(4'h8, "pinA");
        global_bus_a_tx_block_pin = 1'b0;
        global_bus_b_tx_block_pin = 1'b1;
        blk(4'h2, "pinB");
        global_bus_b_tx_block_pin = 1'b0;
        wr(ADDR_MASTER_STAT, 16'h0200);
        blk(4'h8, "mstatA");
        wr(ADDR_MASTER_STAT, 16'h0100);
        blk(4'h2, "mstatB");
        wr(ADDR_MASTER_STAT, 16'h0000);
        blk(4'h0, "mstatNone");
    endtask : t_global

    task automatic wait_to(input int lim, output int n, output logic hit);
        n = 0;
        hit = 1'b0;
        while (!hit && n < lim + 5) begin
            cyc(1);
            n++;
            if (rtRtTimeout === 1'b1) hit = 1'b1;
        end
    endtask : wait_to

    task automatic t_timer();
        int n;
        logic hit;
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_RT_CFG, {s[1:0], 14'h0000});
            busModel.rt_rt(0);
            wait_to(LIM[s], n, hit);
            chk("timeoutCycles", 16'(LIM[s]), 16'(n));
        end
        busModel.rt_rt(LIM[3] / 2);
        wait_to(LIM[3], n, hit);
        chk("timeoutAfterSync", 16'h0000, {15'h0000, hit});
    endtask : t_timer

    task automatic t_soft();
        int n0;
        wr(ADDR_RT_CFG, 16'hF000);
        wr(ADDR_RT_TABLES, 16'hA5A5);
        rd(ADDR_RT_TABLES, 16'hA5A5, "tables");
        chk("tablesBase", 16'hA5A5, rtTablesBase);
        wr(ADDR_MASTER_CFG, 16'h0008);
        n0 = softCount;
        wr(ADDR_MASTER_STAT, 16'h0001);
        chk("softPulses", 16'h0001, 16'(softCount - n0));
        rd(ADDR_RT_CFG, 16'h0000, "cfgAfterSoft");
        rd(ADDR_RT_TABLES, 16'h0000, "tablesAfterSoft");
        chk("tablesBaseAfterSoft", 16'h0000, rtTablesBase);
        rd(ADDR_MASTER_CFG, 16'h0008, "mcfgKept");
        rd(ADDR_MASTER_STAT, 16'h0000, "mstatSelfClear");
        wr(ADDR_MASTER_CFG, 16'h0000);
        n0 = softCount;
        busModel.mode_reset();
        cyc(3);
        chk("modeResetOff", 16'h0000, 16'(softCount - n0));
        wr(ADDR_MASTER_CFG, 16'h0004);
        wr(ADDR_RT_CFG, 16'hF000);
        n0 = softCount;
        busModel.mode_reset();
        cyc(3);
        chk("modeResetOn", 16'h0001, 16'(softCount - n0));
        rd(ADDR_RT_CFG, 16'h0000, "cfgAfterMode");
    endtask : t_soft

    task automatic t_addr();
        logic [4:0] av[3] = '{5'h00, 5'h15, 5'h1F};
        for (int i = 0; i < 6; i++) begin
            termAddrPin = av[i / 2];
            termAddrParityPin = i[0];
            cyc(4);
            chk("addrValid", {15'h0000, ^{av[i / 2], i[0]}}, {15'h0000, termAddrValid});
            chk("addr", {11'h000, av[i / 2]}, {11'h000, termAddr});
        end
    endtask : t_addr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        sys_rst = 1'b1;
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
        termAddrPin = 5'h00;
        termAddrParityPin = 1'b1;
        global_bus_a_tx_block_pin = 1'b0;
        global_bus_b_tx_block_pin = 1'b0;
        cyc(10);
        sys_rst = 1'b0;
        cyc(4);
        t_regs();
        t_global();
        t_timer();
        t_soft();
        t_addr();
        report_and_stop();
    end
endmodule : tb
